/* hw/dpd_pkg.sv */
// Package: constants for the DMA page register and I/O decode block
`default_nettype none
package dpd_pkg;
   // ==========================================
   // Page register, clock chip and coprocessor I/O addresses (10-bit port)
   localparam logic [9:0] PAGE_CH2_ADDR     = 10'h081;
   localparam logic [9:0] PAGE_CH3_ADDR     = 10'h082;
   localparam logic [9:0] PAGE_CH0_ADDR     = 10'h087;
   localparam logic [9:0] PAGE_CH6_ADDR     = 10'h089;
   localparam logic [9:0] PAGE_CH7_ADDR     = 10'h08A;
   localparam logic [9:0] PAGE_REFRESH_ADDR = 10'h08F;
   localparam logic [9:0] CLOCK_DATA_ADDR   = 10'h071;
   // Coprocessor port; the read-enable term decodes SA9 and XA8, not this port
   localparam logic [9:0] COPROC_ADDR       = 10'h0F8;
   // ==========================================
   // Block codes from address bits 9..5
   localparam logic [4:0] BLK_SLAVE_DMAC    = 5'h00;
   localparam logic [4:0] BLK_MASTER_IRQ    = 5'h01;
   localparam logic [4:0] BLK_TIMER         = 5'h02;
   localparam logic [4:0] BLK_PERIPH        = 5'h03;
   localparam logic [4:0] BLK_INTERNAL      = 5'h04;
   localparam logic [4:0] BLK_SLAVE_IRQ     = 5'h05;
   localparam logic [4:0] BLK_MASTER_DMAC   = 5'h06;
   localparam logic [4:0] BLK_COPROC_RESET  = 5'h07;
   // ==========================================
   // Page register file layout
   localparam int unsigned PAGE_WIDTH       = 8;
   localparam int unsigned PAGE_COUNT       = 6;
   localparam logic [7:0]  PAGE_RESET       = 8'h00;
   // Register slot indices
   localparam logic [2:0]  SLOT_CH2         = 3'h0;
   localparam logic [2:0]  SLOT_CH3         = 3'h1;
   localparam logic [2:0]  SLOT_CH0         = 3'h2;
   localparam logic [2:0]  SLOT_CH6         = 3'h3;
   localparam logic [2:0]  SLOT_CH7         = 3'h4;
   localparam logic [2:0]  SLOT_REFRESH     = 3'h5;
   localparam logic [2:0]  SLOT_NONE        = 3'h7;
   // Synchroniser depth for pins
   localparam int unsigned SYNC_STAGES      = 3;
   // Pin levels while idle, in synchroniser bit order
   localparam logic [36:0] PIN_IDLE         = 37'h07EFFFF9FF;
endpackage : dpd_pkg
`default_nettype wire

/* hw/dpd_if.sv */
// Interface: pin samples handed from the synchroniser to the core
`default_nettype none
interface dpd_pin_if #(parameter int unsigned WIDTH = 32);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport sync (input raw, output clean);
   modport core (output raw, input clean);
endinterface : dpd_pin_if
`default_nettype wire

/* hw/dpd_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none
module dpd_sync
   import dpd_pkg::*;
#(
   parameter int unsigned      WIDTH = 32,
   parameter logic [WIDTH-1:0] IDLE  = '1
) (
   input  wire logic i_clock,
   input  wire logic i_resetn,
   input  wire logic i_enable,
   dpd_pin_if.sync   pins
);
   import dpd_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] clean;
   } dpd_sync_state_type;

   dpd_sync_state_type state_ff;
   dpd_sync_state_type nxt_state;

   // ==========================================
   // Next state: a bit moves only when stages two and three agree
   always_comb begin
      nxt_state = state_ff;
      if (i_enable) begin
         nxt_state.s1 = pins.raw;
         nxt_state.s2 = state_ff.s1;
         nxt_state.s3 = state_ff.s2;
         for (int i = 0; i < int'(WIDTH); i++) begin
            if (state_ff.s2[i] == state_ff.s3[i]) begin
               nxt_state.clean[i] = state_ff.s3[i];
            end
         end
      end
   end

   // Reset to each pin's idle level so no false edge follows reset
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= {4{IDLE}};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pins.clean = state_ff.clean;
endmodule : dpd_sync
`default_nettype wire

/* hw/dpd_core.sv */
// DMA page registers, I/O chip-select decode and support strobes
`default_nettype none
module dpd_core
   import dpd_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic        i_enable,
   // CPU and bus control pins
   input  wire logic        i_cpu_hold_ack,
   input  wire logic        i_cpu_ale,
   input  wire logic        i_master_n,
   input  wire logic        i_ior_n,
   input  wire logic        i_iow_n,
   input  wire logic        i_memr_n,
   input  wire logic        i_inta_n,
   input  wire logic        i_coproc_select_n,
   input  wire logic        i_refresh,
   input  wire logic        i_sa9,
   input  wire logic [8:0]  i_x_address_lines,
   // DMA acknowledges, active low: 0,2,3,4,6,7
   input  wire logic        i_dack0_n,
   input  wire logic        i_dack2_n,
   input  wire logic        i_dack3_n,
   input  wire logic        i_dack4_n,
   input  wire logic        i_dack6_n,
   input  wire logic        i_dack7_n,
   // Error and floppy pins
   input  wire logic        i_high_bank_parity_err_n,
   input  wire logic        i_coproc_error,
   input  wire logic        i_controller_step_in,
   input  wire logic        i_seek_enable_in_n,
   input  wire logic        i_nmi_clear,
   // X data bus, split into its three signals
   input  wire logic [7:0]  i_x_data_bus,
   output logic      [7:0]  o_x_data_bus,
   output logic             o_x_data_bus_oe,
   // Chip selects, all active low
   output logic             o_clock_chip_read_strobe_n,
   output logic             o_clock_chip_write_cmd_n,
   output logic             o_slave_dmac_select_n,
   output logic             o_master_irq_ctrl_select_n,
   output logic             o_timer_chip_select_n,
   output logic             o_periph_io_select_n,
   output logic             o_internal_reg_select_n,
   output logic             o_slave_irq_ctrl_select_n,
   output logic             o_master_dmac_select_n,
   output logic             o_coproc_reset_select_n,
   output logic             o_xbus_read_enable_n,
   // Strobes and page outputs
   output logic             o_buffered_latch_enable,
   output logic             o_dma_mode_indication,
   output logic             o_nmi,
   output logic             o_coproc_error_irq,
   output logic             o_drive_step,
   output logic      [6:0]  o_page_address,
   output logic             o_page_bit16_out
);
   import dpd_pkg::*;

   localparam int unsigned NPINS = 37;

   // ==========================================
   // Pin synchroniser
   dpd_pin_if #(.WIDTH(NPINS)) pins ();

   assign pins.raw = {i_cpu_hold_ack, i_cpu_ale, i_master_n, i_ior_n, i_iow_n,
                      i_memr_n, i_inta_n, i_coproc_select_n, i_refresh, i_sa9,
                      i_x_address_lines, i_dack0_n, i_dack2_n, i_dack3_n,
                      i_dack4_n, i_dack6_n, i_dack7_n, i_high_bank_parity_err_n,
                      i_coproc_error, i_controller_step_in, i_seek_enable_in_n,
                      i_x_data_bus};

   dpd_sync #(.WIDTH(NPINS), .IDLE(PIN_IDLE)) u_sync (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_enable (i_enable),
      .pins     (pins)
   );

   logic       hold_ack, ale, master_n, ior_n, iow_n, memr_n, inta_n, cop_n;
   logic       refresh, sa9, dk0, dk2, dk3, dk4, dk6, dk7, par_n, cop_err;
   logic       step_in, seek_n;
   logic [8:0] xa;
   logic [7:0] xd;

   assign {hold_ack, ale, master_n, ior_n, iow_n, memr_n, inta_n, cop_n, refresh,
           sa9, xa, dk0, dk2, dk3, dk4, dk6, dk7, par_n, cop_err, step_in,
           seek_n, xd} = pins.clean;

   // ==========================================
   // Decode helpers
   // Maps a port address to a page register slot
   // page register address map
   function automatic logic [2:0] page_slot(input logic [9:0] addr);
      case (addr)
         PAGE_CH2_ADDR:     page_slot = SLOT_CH2;
         PAGE_CH3_ADDR:     page_slot = SLOT_CH3;
         PAGE_CH0_ADDR:     page_slot = SLOT_CH0;
         PAGE_CH6_ADDR:     page_slot = SLOT_CH6;
         PAGE_CH7_ADDR:     page_slot = SLOT_CH7;
         PAGE_REFRESH_ADDR: page_slot = SLOT_REFRESH;
         default:           page_slot = SLOT_NONE;
      endcase
   endfunction : page_slot

   // ==========================================
   // State
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_MEMRD = 3'b010,
      ST_DONE  = 3'b100
   } dpd_parity_state_type;

   typedef struct packed {
      logic [PAGE_COUNT-1:0][PAGE_WIDTH-1:0] page;
      dpd_parity_state_type                  par_st;
      logic                                  iow_n_d;
      logic [7:0]                            wr_data;
      logic [7:0]                            xd_out;
      logic                                  xd_oe;
      logic [9:0]                            sel_n;
      logic                                  clk_rd_n;
      logic                                  clk_wr_n;
      logic                                  xread_n;
      logic                                  buffered_latch_enable;
      logic                                  dma_mode;
      logic                                  nmi;
      logic                                  coproc_error_irq;
      logic                                  step;
      logic [6:0]                            page_addr;
      logic                                  page16;
   } dpd_state_type;

   dpd_state_type state_ff;
   dpd_state_type nxt_state;

   logic [9:0] port;
   logic       dma_cycle;
   logic [2:0] slot;
   logic [2:0] drive_slot;
   logic       drive_page;

   assign port      = {sa9, xa};
   assign dma_cycle = hold_ack;
   assign slot      = page_slot(port);

   // ==========================================
   // Channel selection for the address drive
   always_comb begin
      drive_page = 1'b1;
      if (refresh) begin
         drive_slot = SLOT_REFRESH;
      end else if (!dk0) begin
         drive_slot = SLOT_CH0;
      end else if (!dk2) begin
         drive_slot = SLOT_CH2;
      end else if (!dk3) begin
         drive_slot = SLOT_CH3;
      end else if (!dk6) begin
         drive_slot = SLOT_CH6;
      end else if (!dk7) begin
         drive_slot = SLOT_CH7;
      end else if (!dk4) begin
         drive_slot = SLOT_NONE;
         drive_page = 1'b0;
      end else begin
         drive_slot = SLOT_NONE;
         drive_page = 1'b0;
      end
   end

   // ==========================================
   // Next-state logic
   always_comb begin
      nxt_state = state_ff;
      if (i_enable) begin
         nxt_state.iow_n_d = iow_n;
         // Data is only promised while the command is low; keep the last byte seen
         if (!iow_n) begin
            nxt_state.wr_data = xd;
         end
         // latch X data on write strobe rise
         if (!dma_cycle && !state_ff.iow_n_d && iow_n && slot != SLOT_NONE) begin
            nxt_state.page[slot] = state_ff.wr_data;
         end

         nxt_state.sel_n = 10'h3FF;
         if (!dma_cycle) begin
            nxt_state.sel_n[0] = !(port[9:5] == BLK_SLAVE_DMAC);
            nxt_state.sel_n[1] = !(port[9:5] == BLK_MASTER_IRQ);
            nxt_state.sel_n[2] = !(port[9:5] == BLK_TIMER);
            nxt_state.sel_n[3] = !(port[9:5] == BLK_PERIPH);
            nxt_state.sel_n[4] = !(port[9:5] == BLK_INTERNAL);
            nxt_state.sel_n[5] = !(port[9:5] == BLK_SLAVE_IRQ);
            nxt_state.sel_n[6] = !(port[9:5] == BLK_MASTER_DMAC);
            nxt_state.sel_n[7] = !(port[9:5] == BLK_COPROC_RESET);
         end

         nxt_state.clk_rd_n = !(!dma_cycle && !ior_n && port == CLOCK_DATA_ADDR);
         nxt_state.clk_wr_n = !(!dma_cycle && !iow_n && port == CLOCK_DATA_ADDR);

         // INTA + COPROC_SELECT*SA9*XA8*IOR, active terms low
         nxt_state.xread_n = !(!inta_n || (!cop_n && sa9 && xa[8] && !ior_n));

         // page register read onto X data
         nxt_state.xd_oe  = 1'b0;
         nxt_state.xd_out = 8'h00;
         // reads carried on X data bus
         if (!dma_cycle && !ior_n && slot != SLOT_NONE) begin
            nxt_state.xd_oe  = 1'b1;
            nxt_state.xd_out = state_ff.page[slot];
         end

         nxt_state.buffered_latch_enable     = ale | hold_ack;
         nxt_state.dma_mode = hold_ack | !master_n;

         nxt_state.coproc_error_irq = cop_err;
         nxt_state.step  = step_in & !seek_n;

         // upper seven bits, bit zero to bit 16
         // bit 16 doubles as SA16 for slave DMA
         if (drive_page) begin
            nxt_state.page_addr = state_ff.page[drive_slot][7:1];
            nxt_state.page16    = state_ff.page[drive_slot][0];
         end else begin
            nxt_state.page_addr = 7'h00;
            nxt_state.page16    = 1'b0;
         end

         // parity sampled at start of memory read
         case (state_ff.par_st)
            ST_IDLE: begin
               if (!memr_n) begin
                  nxt_state.par_st = ST_MEMRD;
                  if (!par_n) begin
                     nxt_state.nmi = 1'b1;
                  end
               end
            end
            ST_MEMRD: begin
               if (memr_n) begin
                  nxt_state.par_st = ST_IDLE;
               end
            end
            default: begin
               nxt_state.par_st = ST_IDLE;
            end
         endcase
         // Set wins: clear only when no new error lands
         if (i_nmi_clear && !(state_ff.par_st == ST_IDLE && !memr_n && !par_n)) begin
            nxt_state.nmi = 1'b0;
         end
      end
   end

   // ==========================================
   // State register; chip selects idle high, support strobes low, pages cleared
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff          <= '0;
         state_ff.page     <= {PAGE_COUNT{PAGE_RESET}};
         state_ff.par_st   <= ST_IDLE;
         state_ff.iow_n_d  <= 1'b1;
         state_ff.sel_n    <= 10'h3FF;
         state_ff.clk_rd_n <= 1'b1;
         state_ff.clk_wr_n <= 1'b1;
         state_ff.xread_n  <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================
   // Outputs straight from the state register
   assign o_x_data_bus               = state_ff.xd_out;
   assign o_x_data_bus_oe            = state_ff.xd_oe;
   assign o_clock_chip_read_strobe_n = state_ff.clk_rd_n;
   assign o_clock_chip_write_cmd_n   = state_ff.clk_wr_n;
   assign o_slave_dmac_select_n      = state_ff.sel_n[0];
   assign o_master_irq_ctrl_select_n = state_ff.sel_n[1];
   assign o_timer_chip_select_n      = state_ff.sel_n[2];
   assign o_periph_io_select_n       = state_ff.sel_n[3];
   assign o_internal_reg_select_n    = state_ff.sel_n[4];
   assign o_slave_irq_ctrl_select_n  = state_ff.sel_n[5];
   assign o_master_dmac_select_n     = state_ff.sel_n[6];
   assign o_coproc_reset_select_n    = state_ff.sel_n[7];
   assign o_xbus_read_enable_n       = state_ff.xread_n;
   assign o_buffered_latch_enable    = state_ff.buffered_latch_enable;
   assign o_dma_mode_indication      = state_ff.dma_mode;
   assign o_nmi                      = state_ff.nmi;
   assign o_coproc_error_irq         = state_ff.coproc_error_irq;
   assign o_drive_step               = state_ff.step;
   assign o_page_address             = state_ff.page_addr;
   assign o_page_bit16_out           = state_ff.page16;
endmodule : dpd_core
`default_nettype wire

/* test/dpd_core_assertions.sv */
// Port-level checker for the page register and I/O decode block
`default_nettype none
module dpd_core_assertions (
   input wire logic       i_clock,
   input wire logic       i_resetn,
   input wire logic       i_cpu_hold_ack,
   input wire logic       i_cpu_ale,
   input wire logic       i_master_n,
   input wire logic       i_ior_n,
   input wire logic       i_iow_n,
   input wire logic       i_sa9,
   input wire logic [8:0] i_x_address_lines,
   input wire logic       i_coproc_error,
   input wire logic       i_controller_step_in,
   input wire logic       i_seek_enable_in_n,
   input wire logic       i_nmi_clear,
   input wire logic       o_clock_chip_read_strobe_n,
   input wire logic       o_clock_chip_write_cmd_n,
   input wire logic       o_slave_dmac_select_n,
   input wire logic       o_periph_io_select_n,
   input wire logic       o_slave_irq_ctrl_select_n,
   input wire logic       o_buffered_latch_enable,
   input wire logic       o_dma_mode_indication,
   input wire logic       o_nmi,
   input wire logic       o_coproc_error_irq,
   input wire logic       o_drive_step
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Shared terms
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   wire logic [9:0] port = {i_sa9, i_x_address_lines};
   // CPU-owned commands only; decode is blind in DMA cycles
   wire logic       rd   = !i_ior_n && !i_cpu_hold_ack;
   wire logic       wr   = !i_iow_n && !i_cpu_hold_ack;
   // Six steady cycles cover the pin synchroniser and output register
   property held(c, o);
      c [*6] |=> o;
   endproperty
   // ==========================================
   // Assertions
   clk_read_a: assert property (held(rd && port == 10'h071, !o_clock_chip_read_strobe_n))
      else $error("clock chip read strobe missing");
   clk_write_a: assert property (held(wr && port == 10'h071, !o_clock_chip_write_cmd_n))
      else $error("clock chip write command missing");
   slave_dmac_a: assert property (held(rd && port[9:5] == 5'h00, !o_slave_dmac_select_n))
      else $error("slave dma controller select missing");
   slave_irq_a: assert property (held(rd && port[9:5] == 5'h05, !o_slave_irq_ctrl_select_n))
      else $error("slave interrupt controller select missing");
   periph_sel_a: assert property (held(rd && port[9:5] == 5'h03, !o_periph_io_select_n))
      else $error("peripheral select missing");
   dma_quiet_a: assert property (held(i_cpu_hold_ack, o_slave_dmac_select_n &&
      o_periph_io_select_n && o_slave_irq_ctrl_select_n && o_clock_chip_read_strobe_n))
      else $error("select active during dma cycle");
   latch_en_a: assert property (held(i_cpu_ale || i_cpu_hold_ack, o_buffered_latch_enable))
      else $error("latch enable missing");
   latch_off_a: assert property (held(!i_cpu_ale && !i_cpu_hold_ack, !o_buffered_latch_enable))
      else $error("latch enable stuck");
   dma_mode_a: assert property (held(i_cpu_hold_ack || !i_master_n, o_dma_mode_indication))
      else $error("dma mode indication missing");
   nmi_sticky_a: assert property (o_nmi && !i_nmi_clear |=> o_nmi)
      else $error("nmi dropped without clear");
   copro_irq_a: assert property (held(i_coproc_error, o_coproc_error_irq))
      else $error("coprocessor error request missing");
   step_pass_a: assert property (held(i_controller_step_in && !i_seek_enable_in_n, o_drive_step))
      else $error("step pulse not passed");
   // Main scenarios reached
   cover property (rd && port == 10'h071);
   cover property (i_cpu_hold_ack ##1 !i_cpu_hold_ack);
   cover property ($rose(o_nmi));
endmodule : dpd_core_assertions
`default_nettype wire

/* test/dpd_bus_model.sv */
// Behavioural CPU bus and DMA controller side of the page and decode block
`default_nettype none
module dpd_bus_model (
   input  wire logic       i_clock,
   input  wire logic [7:0] i_xd,
   output logic            o_ior_n,
   output logic            o_iow_n,
   output logic            o_hold_ack,
   output logic            o_refresh,
   output logic [9:0]      o_port,
   output logic [7:0]      o_xd,
   output logic [5:0]      o_dack_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus: no command, no acknowledge, unused port block
   initial begin
      {o_ior_n, o_iow_n, o_hold_ack, o_refresh} = 4'hC;
      o_port = 10'h3FF;
      o_xd = 8'h00;
      o_dack_n = 6'h3F;
   end
   // One I/O command, held long past the synchroniser delay
   task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      @(negedge i_clock);
      o_port = a;
      o_xd = wr ? d : ~d;
      if (wr) o_iow_n = 1'b0;
      else o_ior_n = 1'b0;
      repeat (7) @(negedge i_clock);
      @(posedge i_clock);
      q = i_xd;
      @(negedge i_clock);
      {o_ior_n, o_iow_n} = 2'h3;
      // Released lines show the inverse, never a stale match
      o_xd = ~d;
      repeat (8) @(negedge i_clock);
   endtask : io
   // Bus ownership and acknowledges; bit order 7,6,4,3,2,0
   task automatic dma(input logic h, input logic r, input logic [5:0] k);
      @(negedge i_clock);
      o_hold_ack = h;
      o_refresh = r;
      o_dack_n = k;
      repeat (8) @(negedge i_clock);
   endtask : dma
endmodule : dpd_bus_model
`default_nettype wire

/* test/tb_dma_page_and_io_decode.sv */
// Self-checking bench for the page register and I/O decode block
`default_nettype none
module tb_dma_page_and_io_decode;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Signals, named as the design ports
   logic i_clock = 1'b0, i_resetn = 1'b0, i_enable = 1'b1, i_cpu_ale = 1'b0;
   logic i_master_n = 1'b1, i_memr_n = 1'b1, i_inta_n = 1'b1, i_coproc_select_n = 1'b1;
   logic i_high_bank_parity_err_n = 1'b1, i_coproc_error = 1'b0, i_nmi_clear = 1'b0;
   logic i_controller_step_in = 1'b0, i_seek_enable_in_n = 1'b1;
   logic i_cpu_hold_ack, i_ior_n, i_iow_n, i_refresh, i_sa9, o_x_data_bus_oe;
   logic i_dack0_n, i_dack2_n, i_dack3_n, i_dack4_n, i_dack6_n, i_dack7_n;
   logic o_clock_chip_read_strobe_n, o_clock_chip_write_cmd_n, o_slave_dmac_select_n;
   logic o_master_irq_ctrl_select_n, o_timer_chip_select_n, o_periph_io_select_n;
   logic o_internal_reg_select_n, o_slave_irq_ctrl_select_n, o_master_dmac_select_n;
   logic o_coproc_reset_select_n, o_xbus_read_enable_n, o_buffered_latch_enable;
   logic o_dma_mode_indication, o_nmi, o_coproc_error_irq, o_drive_step, o_page_bit16_out;
   logic [8:0] i_x_address_lines;
   logic [7:0] i_x_data_bus, o_x_data_bus, bus_xd, q;
   logic [6:0] o_page_address;
   logic [5:0] dack_n;
   logic [9:0] port;
   int         err_count = 0, n_tests = 0, cycles = 0, i;
   // Shared pins; the data wire follows whoever enables it
   assign {i_sa9, i_x_address_lines} = port;
   assign {i_dack7_n, i_dack6_n, i_dack4_n, i_dack3_n, i_dack2_n, i_dack0_n} = dack_n;
   assign i_x_data_bus = o_x_data_bus_oe ? o_x_data_bus : bus_xd;
   wire logic [9:0] sel_low = ~{o_clock_chip_read_strobe_n, o_clock_chip_write_cmd_n,
      o_slave_dmac_select_n, o_master_irq_ctrl_select_n, o_timer_chip_select_n,
      o_periph_io_select_n, o_internal_reg_select_n, o_slave_irq_ctrl_select_n,
      o_master_dmac_select_n, o_coproc_reset_select_n};
   // ==========================================
   // Rows: command, port, selects expected low
   typedef struct packed { logic wr; logic [9:0] a; logic [9:0] low; } dpd_row_type;
   dpd_row_type rows [12] = '{
      '{1'b0, 10'h000, 10'h080}, '{1'b0, 10'h03F, 10'h040}, '{1'b0, 10'h040, 10'h020},
      '{1'b0, 10'h060, 10'h010}, '{1'b0, 10'h071, 10'h210}, '{1'b1, 10'h071, 10'h110},
      '{1'b0, 10'h09F, 10'h008}, '{1'b0, 10'h0A0, 10'h004}, '{1'b1, 10'h0BF, 10'h004},
      '{1'b0, 10'h0DF, 10'h002}, '{1'b0, 10'h0E0, 10'h001}, '{1'b0, 10'h100, 10'h000}};
   logic [9:0] pg_a [6] = '{10'h081, 10'h082, 10'h087, 10'h089, 10'h08A, 10'h08F};
   logic [7:0] pg_d [6] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h01, 8'hFE};
   logic [5:0] pg_k [6] = '{6'h3D, 6'h3B, 6'h3E, 6'h2F, 6'h1F, 6'h3F};
   // ==========================================
   // Instances; checker bound below the module
   dpd_core uut (.*);
   dpd_bus_model bus (
      .i_clock   (i_clock),
      .i_xd      (i_x_data_bus),
      .o_ior_n   (i_ior_n),
      .o_iow_n   (i_iow_n),
      .o_hold_ack(i_cpu_hold_ack),
      .o_refresh (i_refresh),
      .o_port    (port),
      .o_xd      (bus_xd),
      .o_dack_n  (dack_n)
   );
   // Clock and hang guard
   always #50 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         summarize();
      end
   end
   // ==========================================
   // Tasks
   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(negedge i_clock);
   endtask : wt
   // Command plus a select sample at the same edge as the data
   task automatic cyc(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      input logic [9:0] low);
      fork
         bus.io(wr, a, d, q);
         begin
            @(negedge i_clock);
            repeat (8) @(posedge i_clock);
            chk("selects", sel_low, low);
         end
      join
   endtask : cyc
   task automatic summarize;
      $display("%0d checks made, %0d mismatches", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   // ==========================================
   // Main sequence
   initial begin
      wt(5);
      chk("reset state", {o_x_data_bus_oe, o_nmi, o_page_address, o_page_bit16_out}, 10'h000);
      chk("reset selects", sel_low, 10'h000);
      i_resetn = 1'b1;
      wt(6);
      foreach (rows[i]) cyc(rows[i].wr, rows[i].a, 8'h00, rows[i].low);
      $display("test decode done");
      for (i = 0; i < 6; i++) cyc(1'b1, pg_a[i], pg_d[i], 10'h008);
      for (i = 0; i < 6; i++) begin
         cyc(1'b0, pg_a[i], pg_d[i], 10'h008);
         chk("page read", q, pg_d[i]);
         bus.dma(i < 5, i == 5, pg_k[i]);
         chk("page drive", {o_page_address, o_page_bit16_out}, pg_d[i]);
         chk("dma strobes", {o_buffered_latch_enable, o_dma_mode_indication}, {i < 5, i < 5});
         bus.dma(1'b0, 1'b0, 6'h3F);
      end
      $display("test pages done");
      bus.dma(1'b1, 1'b0, 6'h37);
      chk("cascade page", {o_page_address, o_page_bit16_out}, 10'h000);
      bus.dma(1'b1, 1'b0, 6'h3D);
      cyc(1'b1, 10'h081, 8'h55, 10'h000);
      chk("page kept", {o_page_address, o_page_bit16_out}, 10'h0A5);
      bus.dma(1'b0, 1'b0, 6'h3F);
      $display("test dma write refused done");
      i_cpu_ale = 1'b1;
      i_master_n = 1'b0;
      wt(8);
      chk("cpu strobes", {o_buffered_latch_enable, o_dma_mode_indication}, 10'h003);
      i_cpu_ale = 1'b0;
      i_master_n = 1'b1;
      wt(8);
      chk("strobes idle", {o_buffered_latch_enable, o_dma_mode_indication}, 10'h000);
      i_high_bank_parity_err_n = 1'b0;
      i_coproc_error = 1'b1;
      i_controller_step_in = 1'b1;
      i_seek_enable_in_n = 1'b0;
      wt(1);
      i_memr_n = 1'b0;
      wt(8);
      chk("error pins", {o_nmi, o_coproc_error_irq, o_drive_step}, 10'h007);
      {i_memr_n, i_high_bank_parity_err_n, i_coproc_error, i_seek_enable_in_n} = 4'hD;
      wt(8);
      chk("nmi stands", {o_nmi, o_coproc_error_irq, o_drive_step}, 10'h004);
      i_nmi_clear = 1'b1;
      wt(8);
      chk("nmi cleared", o_nmi, 10'h000);
      i_nmi_clear = 1'b0;
      i_inta_n = 1'b0;
      wt(8);
      chk("read enable", o_xbus_read_enable_n, 10'h000);
      i_inta_n = 1'b1;
      i_coproc_select_n = 1'b0;
      fork
         cyc(1'b0, 10'h300, 8'h00, 10'h000);
         begin
            wt(8);
            chk("coproc read enable", o_xbus_read_enable_n, 10'h000);
         end
      join
      i_coproc_select_n = 1'b1;
      chk("read enable idle", o_xbus_read_enable_n, 10'h001);
      $display("test strobes and errors done");
      i_resetn = 1'b0;
      wt(2);
      chk("mid reset", {sel_low[9:1], o_x_data_bus_oe}, 10'h000);
      i_resetn = 1'b1;
      wt(6);
      cyc(1'b0, 10'h081, 8'h00, 10'h008);
      chk("page after reset", q, 10'h000);
      $display("test second reset done");
      summarize();
   end
endmodule : tb_dma_page_and_io_decode
bind dpd_core dpd_core_assertions chk_i (.*);
`default_nettype wire
